/* File: hdl/smct_consts.svh */
// Timing counts and widths for the shared-memory cycle timer
`ifndef SMCT_CONSTS_SVH
`define SMCT_CONSTS_SVH
`define SMCT_ADDR_W 24
`define SMCT_ROW_W 12
`define SMCT_DATA_W 32
`define SMCT_MCLK_DIV 8'h08
`define SMCT_DS_WAIT 3'h2
`define SMCT_PH_DRAM 3'h1
`define SMCT_SRAM_MIN 3'h1
`define SMCT_SRAM_MAX 3'h4
`endif

/* File: hdl/smct_pkg.sv */
// Types for the shared-memory cycle timer
package smct_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_WAIT = 4'h1,
		ST_BEGIN = 4'h2,
		ST_RAS = 4'h3,
		ST_CAS = 4'h4,
		ST_TAIL = 4'h5,
		ST_SACT = 4'h6,
		ST_SEND = 4'h7
	} smct_state_t;
endpackage

/* File: hdl/smct_timer.sv */
// Shared-memory cycle sequencer for DRAM and SRAM access
`include "smct_consts.svh"
module smct_timer (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Processor request
	input wire logic data_strobe_i,
	input wire logic write_i,
	input wire logic dram_sel_i,
	input wire logic [2:0] sram_width_i,
	input wire logic [`SMCT_ADDR_W-1:0] addr_i,
	input wire logic [`SMCT_DATA_W-1:0] wdata_i,
	output logic busy_o,
	output logic done_o,
	output logic [`SMCT_DATA_W-1:0] rdata_o,
	// Memory side
	output logic row_strobe_n_o,
	output logic column_strobe_n_o,
	output logic write_strobe_n_o,
	output logic output_enable_n_o,
	output logic chip_enable_n_o,
	output logic [`SMCT_ADDR_W-1:0] mem_addr_o,
	output logic [`SMCT_DATA_W-1:0] mem_wdata_o,
	output logic mem_wdata_oe_b_o,
	input wire logic [`SMCT_DATA_W-1:0] mem_rdata_i
);
	smct_pkg::smct_state_t st_r, st_nxt;
	logic [7:0] div_r, div_nxt;
	logic tick, half;
	logic [2:0] cnt_r, cnt_nxt;
	logic [2:0] swid_r, swid_nxt;
	logic wr_r, wr_nxt;
	logic ras_r, ras_nxt, cas_r, cas_nxt, we_r, we_nxt;
	logic oe_r, oe_nxt, ce_r, ce_nxt, col_r, col_nxt;
	logic done_r, done_nxt, doe_r, doe_nxt;
	logic [`SMCT_ADDR_W-1:0] addr_r, addr_nxt;
	logic [`SMCT_DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;

	// Clamp the static strobe width into its legal span
	function automatic logic [2:0] clamp_w(input logic [2:0] w);
		if (w < `SMCT_SRAM_MIN) begin
			return `SMCT_SRAM_MIN;
		end else if (w > `SMCT_SRAM_MAX) begin
			return `SMCT_SRAM_MAX;
		end
		return w;
	endfunction

	// Master clock enable; half marks mid period for the address switch
	always_comb begin
		div_nxt = (div_r == `SMCT_MCLK_DIV - 8'h01) ? 8'h00 : div_r + 8'h01;
		tick = (div_r == `SMCT_MCLK_DIV - 8'h01);
		half = (div_r == (`SMCT_MCLK_DIV >> 1) - 8'h01);
	end

	// Sequencer: every strobe moves only on a tick, column address mid phase
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		swid_nxt = swid_r;
		wr_nxt = wr_r;
		ras_nxt = ras_r;
		cas_nxt = cas_r;
		we_nxt = we_r;
		oe_nxt = oe_r;
		ce_nxt = ce_r;
		col_nxt = col_r;
		done_nxt = 1'b0;
		doe_nxt = doe_r;
		addr_nxt = addr_r;
		wd_nxt = wd_r;
		rd_nxt = rd_r;
		// Address flips half a period after row falls, inside the window
		if (half && st_r == smct_pkg::ST_RAS && !col_r) begin
			col_nxt = 1'b1;
		end
		if (tick) begin
			unique case (st_r)
				smct_pkg::ST_IDLE: begin
					if (data_strobe_i) begin
						wr_nxt = write_i;
						addr_nxt = addr_i;
						wd_nxt = wdata_i;
						swid_nxt = clamp_w(sram_width_i);
						cnt_nxt = `SMCT_DS_WAIT;
						st_nxt = smct_pkg::ST_WAIT;
					end
				end
				smct_pkg::ST_WAIT: begin
					// Count counts whole ticks so the gap is at least two
					if (cnt_r == 3'h1) begin
						st_nxt = dram_sel_i ? smct_pkg::ST_BEGIN
							: smct_pkg::ST_SACT;
						if (!dram_sel_i) begin
							oe_nxt = ~wr_r;
							ce_nxt = wr_r;
							doe_nxt = wr_r;
							cnt_nxt = swid_r;
						end
					end else begin
						cnt_nxt = cnt_r - 3'h1;
					end
				end
				smct_pkg::ST_BEGIN: begin
					// Cycle begins; row falls one period later
					ras_nxt = 1'b1;
					we_nxt = wr_r;
					doe_nxt = wr_r;
					st_nxt = smct_pkg::ST_RAS;
				end
				smct_pkg::ST_RAS: begin
					cas_nxt = 1'b1;
					st_nxt = smct_pkg::ST_CAS;
				end
				smct_pkg::ST_CAS: begin
					// One period with column low, then release
					cas_nxt = 1'b0;
					we_nxt = 1'b0;
					if (!wr_r) begin
						rd_nxt = mem_rdata_i;
					end
					st_nxt = smct_pkg::ST_TAIL;
				end
				smct_pkg::ST_TAIL: begin
					ras_nxt = 1'b0;
					col_nxt = 1'b0;
					doe_nxt = 1'b0;
					done_nxt = 1'b1;
					st_nxt = smct_pkg::ST_IDLE;
				end
				smct_pkg::ST_SACT: begin
					if (cnt_r == 3'h1) begin
						if (!wr_r) begin
							rd_nxt = mem_rdata_i;
						end
						oe_nxt = 1'b0;
						ce_nxt = 1'b0;
						st_nxt = smct_pkg::ST_SEND;
					end else begin
						cnt_nxt = cnt_r - 3'h1;
					end
				end
				smct_pkg::ST_SEND: begin
					// Extra period closing the static cycle
					doe_nxt = 1'b0;
					done_nxt = 1'b1;
					st_nxt = smct_pkg::ST_IDLE;
				end
				default: begin
					st_nxt = smct_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// State registers; strobes kept active-high inside, inverted at pins
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= smct_pkg::ST_IDLE;
			div_r <= 8'h00;
			cnt_r <= 3'h0;
			swid_r <= 3'h1;
			wr_r <= 1'b0;
			ras_r <= 1'b0;
			cas_r <= 1'b0;
			we_r <= 1'b0;
			oe_r <= 1'b0;
			ce_r <= 1'b0;
			col_r <= 1'b0;
			done_r <= 1'b0;
			doe_r <= 1'b0;
			addr_r <= '0;
			wd_r <= '0;
			rd_r <= '0;
		end else begin
			st_r <= st_nxt;
			div_r <= div_nxt;
			cnt_r <= cnt_nxt;
			swid_r <= swid_nxt;
			wr_r <= wr_nxt;
			ras_r <= ras_nxt;
			cas_r <= cas_nxt;
			we_r <= we_nxt;
			oe_r <= oe_nxt;
			ce_r <= ce_nxt;
			col_r <= col_nxt;
			done_r <= done_nxt;
			doe_r <= doe_nxt;
			addr_r <= addr_nxt;
			wd_r <= wd_nxt;
			rd_r <= rd_nxt;
		end
	end

	// Outputs; strobes idle high between cycles
	assign row_strobe_n_o = ~ras_r;
	assign column_strobe_n_o = ~cas_r;
	assign write_strobe_n_o = ~we_r;
	assign output_enable_n_o = ~oe_r;
	assign chip_enable_n_o = ~ce_r;
	assign mem_wdata_o = wd_r;
	assign mem_wdata_oe_b_o = ~doe_r;
	assign rdata_o = rd_r;
	assign done_o = done_r;
	assign busy_o = (st_r != smct_pkg::ST_IDLE);
	// Column address taken from upper bits, zero padded
	assign mem_addr_o = col_r
		? {{(`SMCT_ADDR_W-`SMCT_ROW_W){1'b0}},
			addr_r[`SMCT_ADDR_W-1:`SMCT_ROW_W]}
		: addr_r;

	// Checks; sampled at the system clock, so a master period is 8 samples
	a_strobe_on_tick: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		!$past(tick) |-> $stable(ras_r) && $stable(cas_r) && $stable(we_r)
		&& $stable(oe_r) && $stable(ce_r))
		else $error("strobe moved off tick");
	a_idle_strobes_high: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) st_r == smct_pkg::ST_IDLE |->
		row_strobe_n_o && column_strobe_n_o && output_enable_n_o
		&& chip_enable_n_o && write_strobe_n_o)
		else $error("strobe low while idle");
	// Whole master periods: the next strobe edge is seen 8 samples later
	a_ras_to_cas: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$fell(row_strobe_n_o) |-> column_strobe_n_o [*8] ##1
		!column_strobe_n_o)
		else $error("column not one period after row");
	a_cas_width: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$fell(column_strobe_n_o) |-> !column_strobe_n_o [*8] ##1
		column_strobe_n_o)
		else $error("column low width wrong");
	a_we_rise: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$fell(column_strobe_n_o) && wr_r |-> ##8 $rose(write_strobe_n_o))
		else $error("write strobe rise late");
	a_end_after_cas: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) $rose(column_strobe_n_o) |-> ##8 done_r)
		else $error("dram cycle end wrong");
	a_end_after_we: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) $rose(write_strobe_n_o) |-> ##8 done_r)
		else $error("write cycle end wrong");
	a_addr_switch: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$fell(row_strobe_n_o) |-> !col_r [*4] ##1 col_r)
		else $error("address switch wrong");
	a_data_valid: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$fell(row_strobe_n_o) && wr_r |-> !mem_wdata_oe_b_o)
		else $error("write data not driven");
	a_we_with_row: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$fell(row_strobe_n_o) && wr_r |-> !write_strobe_n_o)
		else $error("write strobe not low with row");
	a_read_no_drive: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$fell(column_strobe_n_o) && !wr_r |->
		mem_wdata_oe_b_o && write_strobe_n_o)
		else $error("bus driven during read");
	// Two full master periods of quiet strobes after the request is taken
	a_ds_gap: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		tick && st_r == smct_pkg::ST_IDLE && data_strobe_i |->
		##1 (row_strobe_n_o && output_enable_n_o && chip_enable_n_o) [*8]
		##1 (row_strobe_n_o && output_enable_n_o && chip_enable_n_o) [*8])
		else $error("cycle started too soon");
	a_sram_oe: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$rose(output_enable_n_o) |-> ##8 done_r)
		else $error("sram read tail wrong");
	a_sram_oe_width: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$fell(output_enable_n_o) |-> !output_enable_n_o [*8])
		else $error("output enable too short");
	a_sram_ce: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$fell(chip_enable_n_o) |-> !chip_enable_n_o [*8])
		else $error("chip enable too short");
	a_ce_tail: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$rose(chip_enable_n_o) |-> ##8 done_r)
		else $error("sram write tail wrong");
	a_oe_ce_apart: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		!output_enable_n_o |-> chip_enable_n_o && row_strobe_n_o)
		else $error("static read overlaps other strobes");
	a_ras_after_begin: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) tick && st_r == smct_pkg::ST_BEGIN |->
		##1 !row_strobe_n_o)
		else $error("row late");
	a_read_end: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		$rose(column_strobe_n_o) && !wr_r |-> ##[1:8] done_r)
		else $error("read cycle end late");
	a_done_pulse: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) done_r |=> !done_r)
		else $error("done longer than one clock");
endmodule

/* File: sim/smct_mem_model.sv */
// Behavioural external RAM seen by the cycle timer
module smct_mem_model (
	// Clock
	input wire logic clk_i,
	// Memory side, driven by the timer
	input wire logic column_strobe_n_i,
	input wire logic output_enable_n_i,
	input wire logic chip_enable_n_i,
	input wire logic [23:0] mem_addr_i,
	input wire logic [31:0] mem_wdata_i,
	input wire logic mem_wdata_oe_b_i,
	// Read data back to the timer
	output logic [31:0] mem_rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [16];
	logic [31:0] last = 32'h0;
	logic rd;
	// Drives only while selected; else inverse so no stale match
	assign rd = !column_strobe_n_i || !output_enable_n_i;
	assign mem_rdata_o = rd ? mem[mem_addr_i[3:0]] : ~last;
	// Store whatever the device drives while column strobe or chip enable is low
	always @(posedge clk_i) begin
		if (!mem_wdata_oe_b_i && (!column_strobe_n_i || !chip_enable_n_i))
			mem[mem_addr_i[3:0]] <= mem_wdata_i;
		if (rd)
			last <= mem[mem_addr_i[3:0]];
	end
endmodule

/* File: sim/smct_timer_tb.sv */
// Self-checking bench for the shared-memory cycle timer
`include "smct_consts.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
	$display("ERROR %0t got %h want %h", $time, a, e); end end
module smct_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ds = 1'b0, we = 1'b0, dr = 1'b0;
	logic [2:0] sw = 3'h1;
	logic [23:0] ad = 24'h0, row_a, col_a;
	logic [31:0] wd = 32'h0, rdata, mwd, mrd;
	logic busy, done, rs, cs, ws, oe, ce, moe;
	logic [23:0] ma;
	int bad_count = 0, cmp_count = 0, lat, nrow, ncol, write_strobe_n, output_enable_n, chip_enable_n;
	always #2 clk = ~clk;
	smct_timer smct_timer_i (.clk_i(clk), .rst_b_i(rst_b),
		.data_strobe_i(ds), .write_i(we), .dram_sel_i(dr),
		.sram_width_i(sw), .addr_i(ad), .wdata_i(wd), .busy_o(busy),
		.done_o(done), .rdata_o(rdata), .row_strobe_n_o(rs),
		.column_strobe_n_o(cs), .write_strobe_n_o(ws),
		.output_enable_n_o(oe), .chip_enable_n_o(ce), .mem_addr_o(ma),
		.mem_wdata_o(mwd), .mem_wdata_oe_b_o(moe), .mem_rdata_i(mrd));
	smct_mem_model smct_mem_model_i (.clk_i(clk), .column_strobe_n_i(cs),
		.output_enable_n_i(oe), .chip_enable_n_i(ce), .mem_addr_i(ma),
		.mem_wdata_i(mwd), .mem_wdata_oe_b_i(moe), .mem_rdata_o(mrd));
	// Strobe low-time counters, cleared while a request waits to be taken;
	// one process owns them so the tasks never race their updates
	always @(posedge clk) begin
		if (!rs && nrow == 0) row_a <= ma;
		if (!cs && ncol == 0) col_a <= ma;
		if (ds && !busy) begin
			{nrow, ncol, write_strobe_n, output_enable_n, chip_enable_n} <= '0;
		end else begin
			nrow <= nrow + int'(!rs);
			ncol <= ncol + int'(!cs);
			write_strobe_n <= write_strobe_n + int'(!ws);
			output_enable_n <= output_enable_n + int'(!oe);
			chip_enable_n <= chip_enable_n + int'(!ce);
		end
	end
	task automatic stop_test();
		$display("compares %0d errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One whole memory cycle; lat counts clocks from take to done
	task automatic cyc(input logic w, d, input logic [2:0] wi,
		input logic [23:0] a, input logic [31:0] dat);
		int n;
		@(negedge clk);
		{we, dr, sw, ad, wd, ds} = {w, d, wi, a, dat, 1'b1};
		n = 0;
		do begin @(posedge clk); #1; n++; end while (!busy && n < 20);
		@(negedge clk);
		ds = 1'b0;
		lat = 0;
		do begin @(posedge clk); #1; lat++; end while (!done && lat < 99);
		`CHK({rs, cs, ws, oe, ce}, 5'h1F)
	endtask
	task automatic t_dram();
		cyc(1'b1, 1'b1, 3'h1, 24'h00A5C3, 32'hCAFE1234);
		`CHK(lat, 48)
		`CHK(nrow, 24)
		`CHK({ncol, write_strobe_n}, {32'd8, 32'd16})
		`CHK({row_a, col_a}, {24'h00A5C3, 24'h00000A})
		cyc(1'b0, 1'b1, 3'h1, 24'h00A5C3, 32'h0);
		`CHK(lat, 48)
		`CHK({ncol, write_strobe_n}, {32'd8, 32'd0})
		`CHK(rdata, 32'hCAFE1234)
	endtask
	// Width codes 0 to 5, including clamped 0 and 5
	task automatic t_sram();
		int e;
		for (int w = 0; w < 6; w++) begin
			e = (w == 0) ? 1 : ((w > 4) ? 4 : w);
			cyc(1'b1, 1'b0, w[2:0], 24'h000003, 32'h5A000000 + w);
			`CHK({chip_enable_n, output_enable_n, nrow}, {32'(8 * e), 64'd0})
			`CHK(lat, (3 + e) * 8)
			cyc(1'b0, 1'b0, w[2:0], 24'h000003, 32'h0);
			`CHK({output_enable_n, chip_enable_n}, {32'(8 * e), 32'd0})
			`CHK(lat, (3 + e) * 8)
			`CHK(rdata, 32'h5A000000 + w)
		end
	endtask
	initial begin
		repeat (10) @(negedge clk);
		`CHK({busy, done, rs, cs, ws, oe, ce}, 7'h1F)
		rst_b = 1'b1;
		t_dram();
		t_sram();
		stop_test();
	end
	// Watchdog: run needs roughly 700 clocks
	initial begin
		#40000;
		bad_count++;
		stop_test();
	end
endmodule
